// ===== scan_acq_pkg.sv
package scan_acq_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int     CLK_PERIOD_NS   = 100;
  localparam longint CLK_HZ          = 64'd10_000_000;
  localparam int     CONV_TIME_NS    = 8000;
  localparam int     CONV_CYC        = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int     CONV_CNT_W      = 7;
  localparam longint MAX_RATE_SPS    = 64'd100_000;
  localparam longint MIN_PERIOD_CYC  = (CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
  localparam longint SLOW_RATE_MSPS  = 64'd4;
  localparam longint MAX_PERIOD_CYC  = (CLK_HZ * 64'd1000) / SLOW_RATE_MSPS;
  localparam int     TRIG_LAT_NS     = 1000;
  localparam int     TRIG_LAT_CYC    = TRIG_LAT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // data layout
  // ----------------------------------------------------------------
  localparam int RESULT_W    = 12;
  localparam int NUM_CH      = 8;
  localparam int CH_W        = 3;
  localparam int SAMPLE_W    = CH_W + RESULT_W;
  localparam int FIFO_DEPTH  = 7168;
  localparam int NVM_BYTES   = 4096;
  localparam int NVM_AW      = 12;
  localparam int STRAP_W     = 3;
  localparam int PERIOD_W    = 32;
  localparam int STATUS_CNT_W = 13;

  // ----------------------------------------------------------------
  // serial host link
  // ----------------------------------------------------------------
  localparam int         SPI_CMD_BITS   = 8;
  localparam int         SPI_FRAME_BITS = 24;
  localparam int         SPI_WORD_W     = 16;
  localparam logic [7:0] CMD_READ_FIFO  = 8'h01;
  localparam logic [7:0] CMD_STATUS     = 8'h02;
  localparam logic [7:0] CMD_NVM_READ   = 8'h03;
  localparam logic [7:0] CMD_NVM_ADDR   = 8'h04;

  // ----------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRIG_RISE = 2'h0,
    TRIG_FALL = 2'h1,
    TRIG_HIGH = 2'h2,
    TRIG_LOW  = 2'h3
  } trig_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ARMED = 3'h1,
    ST_RUN   = 3'h2,
    ST_CONV  = 3'h3,
    ST_STORE = 3'h4
  } seq_state_e;

endpackage : scan_acq_pkg

// ===== scan_acquisition_control.sv
`timescale 1ns/1ns
// Contract
// [RULE_01] each conversion yields a 12-bit code
// [RULE_02] internal pacing from 0.004 S/s to 100 kS/s
// [RULE_03] external pacing clock at most 100 kS/s
// [RULE_04] one conversion per enabled channel per tick
// [RULE_05] conversions spaced 8 us apart
// [RULE_06] pacing source internal or external terminal
// [RULE_07] up to eight unique ascending channels
// [RULE_08] trigger on rise, fall, high or low
// [RULE_09] internal pacing starts within 1 us
// [RULE_10] external start within 1 us plus period
// [RULE_11] clock terminal input when not acquiring
// [RULE_12] output mode drives pacing clock, rising marks scan
// [RULE_13] input mode scans on each external rise
// [RULE_14] samples buffered in 7168-deep FIFO
// [RULE_15] 4 KB identity store, never written
// [RULE_16] slave on chip select zero, mode 1
// [RULE_17] host serial clock at most 10 MHz; code samples it on the 10 MHz ref_clk, below 5 MHz only
// [RULE_18] strapped board address on three lines
// [RULE_19] samples stored in scan-list order
module scan_acquisition_control
  import scan_acq_pkg::*;
#(
  parameter logic [PERIOD_W-1:0] MAX_PERIOD = PERIOD_W'(MAX_PERIOD_CYC),
  parameter int                  FDEPTH     = FIFO_DEPTH
)(
  input  wire logic                ref_clk,               // system clock
  input  wire logic                nrst,                  // async reset, active low
  input  wire logic                acq_enable,            // run acquisition
  input  wire logic                trig_enable,           // wait for trigger
  input  wire logic [1:0]          trig_mode,             // trigger condition
  input  wire logic                clk_dir_out,           // 1 drive pacing clock
  input  wire logic [PERIOD_W-1:0] scan_period,           // internal period, cycles
  input  wire logic [NUM_CH-1:0]   chan_mask,             // enabled channels
  input  wire logic                trig_in,               // trigger pin
  input  wire logic                scan_clk_in,           // clock terminal input
  output      logic                scan_clk_out,          // clock terminal output
  output      logic                scan_clk_oe,           // clock terminal enable
  output      logic                adc_start,             // conversion start pulse
  output      logic [CH_W-1:0]     adc_channel,           // channel converting
  input  wire logic [RESULT_W-1:0] adc_code,              // converter result
  input  wire logic                spi_sclk,              // host serial clock
  input  wire logic                spi_mosi,              // host data in
  input  wire logic                host_chip_select_zero_n, // select, active low
  output      logic                spi_miso,              // data to host
  output      logic                spi_miso_oe,           // miso enable
  output      logic [NVM_AW-1:0]   nvm_addr,              // identity store address
  input  wire logic [7:0]          nvm_data,              // identity store byte
  input  wire logic [STRAP_W-1:0]  addr_strap,            // board address straps
  output      logic [STRAP_W-1:0]  board_addr,            // latched board address
  output      logic                acq_running,           // acquisition active
  output      logic                scan_overrun           // tick lost while busy
);

  localparam int FCNT_W  = $clog2(FDEPTH + 1);
  localparam int LAT_MAX = 10;

  typedef struct packed {
    seq_state_e            state;
    logic                  trig_s1, trig_s2, trig_prev;
    logic                  eclk_s1, eclk_s2, eclk_prev;
    logic [PERIOD_W-1:0]   div_cnt;
    logic                  clk_out, clk_oe;
    logic [CH_W-1:0]       chan;
    logic [CONV_CNT_W-1:0] conv_cnt;
    logic [RESULT_W-1:0]   sample;
    logic                  adc_start, overrun, running;
    logic                  sclk_s1, sclk_s2, sclk_prev;
    logic                  cs_s1, cs_s2, mosi_s1, mosi_s2;
    logic [4:0]            bit_cnt;
    logic [SPI_WORD_W-1:0] shift_in;
    logic [7:0]            cmd;
    logic [SPI_WORD_W-1:0] shift_out;
    logic                  miso, miso_oe;
    logic [NVM_AW-1:0]     nvm_ptr;
    logic [STRAP_W-1:0]    strap_s1, strap_s2, board_addr;
    logic [1:0]            strap_cnt;
  } state_s;

  state_s                r_reg;
  state_s                r_next;
  logic                  fifo_in_valid;
  logic                  fifo_in_ready;
  logic [SAMPLE_W-1:0]   fifo_in_data;
  logic                  fifo_out_valid;
  logic                  fifo_pop;
  logic [SAMPLE_W-1:0]   fifo_out_data;
  logic [FCNT_W-1:0]     fifo_count;
  logic                  trig_hit;
  logic                  tick;
  logic                  advance;
  logic                  start_acq;
  logic [PERIOD_W-1:0]   period;
  logic [CH_W:0]         pick;
  logic                  sfall;
  logic                  srise;

  // first enabled channel at or above 'from'; msb flags found
  function automatic logic [CH_W:0] next_chan(input logic [NUM_CH-1:0] mask,
                                              input logic [CH_W:0]     from);
    next_chan = '0;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (mask[i] && (i >= int'(from)))
      begin
        next_chan = {1'b1, CH_W'(i)};
      end
    end
  endfunction : next_chan

  // ----------------------------------------------------------------
  // sample buffer
  // ----------------------------------------------------------------
  scan_sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FDEPTH),
    .CNT_W (FCNT_W)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  ); // [RULE_14]

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_next        = r_reg;
    fifo_in_valid = 1'b0;
    fifo_in_data  = '0;
    fifo_pop      = 1'b0;
    tick          = 1'b0;
    advance       = 1'b0;
    start_acq     = 1'b0;
    pick          = '0;
    r_next.adc_start = 1'b0;

    r_next.trig_s1   = trig_in;
    r_next.trig_s2   = r_reg.trig_s1;
    r_next.trig_prev = r_reg.trig_s2;
    r_next.eclk_s1   = scan_clk_in;
    r_next.eclk_s2   = r_reg.eclk_s1;
    r_next.eclk_prev = r_reg.eclk_s2;

    case (trig_mode_e'(trig_mode)) // [RULE_08]
      TRIG_RISE: trig_hit = r_reg.trig_s2 & ~r_reg.trig_prev;
      TRIG_FALL: trig_hit = ~r_reg.trig_s2 & r_reg.trig_prev;
      TRIG_HIGH: trig_hit = r_reg.trig_s2;
      TRIG_LOW:  trig_hit = ~r_reg.trig_s2;
      default:   trig_hit = 1'b0;
    endcase

    // clamp pacing period to the supported rate span
    if (scan_period < PERIOD_W'(MIN_PERIOD_CYC)) // [RULE_02]
      period = PERIOD_W'(MIN_PERIOD_CYC);
    else if (scan_period > MAX_PERIOD)
      period = MAX_PERIOD;
    else
      period = scan_period;

    // pacing source while acquiring
    if (r_reg.state == ST_RUN || r_reg.state == ST_CONV || r_reg.state == ST_STORE)
    begin
      if (clk_dir_out) // [RULE_06]
      begin
        if (r_reg.div_cnt == '0)
        begin
          tick           = 1'b1; // [RULE_12]
          r_next.div_cnt = period - 1'b1;
          r_next.clk_out = 1'b1;
        end
        else
        begin
          r_next.div_cnt = r_reg.div_cnt - 1'b1;
          if (r_reg.div_cnt == (period >> 1))
            r_next.clk_out = 1'b0;
        end
      end
      else
      begin
        tick           = r_reg.eclk_s2 & ~r_reg.eclk_prev; // [RULE_13] [RULE_10]
        r_next.clk_out = 1'b0;
      end
    end

    case (r_reg.state)
      ST_IDLE:
      begin
        if (acq_enable)
        begin
          r_next.overrun = 1'b0;
          if (trig_enable)
            r_next.state = ST_ARMED;
          else
            start_acq = 1'b1;
        end
      end
      ST_ARMED:
      begin
        if (trig_hit)
          start_acq = 1'b1; // [RULE_09]
      end
      ST_RUN:
      begin
        pick = next_chan(chan_mask, '0);
        if (tick && pick[CH_W]) // [RULE_04]
        begin
          r_next.chan      = pick[CH_W-1:0];
          r_next.conv_cnt  = CONV_CNT_W'(CONV_CYC - 1);
          r_next.adc_start = 1'b1;
          r_next.state     = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (tick)
          r_next.overrun = 1'b1;
        if (r_reg.conv_cnt == '0)
        begin
          fifo_in_valid = 1'b1; // [RULE_01]
          fifo_in_data  = {r_reg.chan, adc_code};
          r_next.sample = adc_code;
          if (fifo_in_ready)
            advance = 1'b1;
          else
            r_next.state = ST_STORE;
        end
        else
        begin
          r_next.conv_cnt = r_reg.conv_cnt - 1'b1; // [RULE_05]
        end
      end
      ST_STORE:
      begin
        if (tick)
          r_next.overrun = 1'b1;
        fifo_in_valid = 1'b1;
        fifo_in_data  = {r_reg.chan, r_reg.sample};
        if (fifo_in_ready)
          advance = 1'b1;
      end
      default:
      begin
        r_next.state = ST_IDLE;
      end
    endcase

    if (start_acq)
    begin
      r_next.state   = ST_RUN;
      r_next.div_cnt = '0;
    end

    // next higher channel of the same scan, else wait for next tick
    if (advance)
    begin
      pick = next_chan(chan_mask, {1'b0, r_reg.chan} + 1'b1); // [RULE_07] [RULE_19]
      if (pick[CH_W])
      begin
        r_next.chan      = pick[CH_W-1:0];
        r_next.conv_cnt  = CONV_CNT_W'(CONV_CYC - 1);
        r_next.adc_start = 1'b1;
        r_next.state     = ST_CONV;
      end
      else
      begin
        r_next.state = ST_RUN;
      end
    end

    if (!acq_enable)
    begin
      r_next.state     = ST_IDLE;
      r_next.clk_out   = 1'b0;
      r_next.adc_start = 1'b0;
    end

    r_next.running = (r_next.state == ST_RUN) || (r_next.state == ST_CONV) ||
                     (r_next.state == ST_STORE);
    r_next.clk_oe  = clk_dir_out & r_next.running; // [RULE_11]

    // host serial slave, mode 1: shift out on rise, sample on fall
    r_next.sclk_s1   = spi_sclk;
    r_next.sclk_s2   = r_reg.sclk_s1;
    r_next.sclk_prev = r_reg.sclk_s2;
    r_next.cs_s1     = host_chip_select_zero_n;
    r_next.cs_s2     = r_reg.cs_s1;
    r_next.mosi_s1   = spi_mosi;
    r_next.mosi_s2   = r_reg.mosi_s1;
    sfall = r_reg.sclk_prev & ~r_reg.sclk_s2;
    srise = ~r_reg.sclk_prev & r_reg.sclk_s2;

    if (r_reg.cs_s2)
    begin
      r_next.bit_cnt = '0;
      r_next.miso    = 1'b0;
      r_next.miso_oe = 1'b0;
    end
    else
    begin
      r_next.miso_oe = 1'b1; // [RULE_16]
      if (sfall)
      begin
        r_next.shift_in = {r_reg.shift_in[SPI_WORD_W-2:0], r_reg.mosi_s2};
        if (r_reg.bit_cnt != 5'h1f)
          r_next.bit_cnt = r_reg.bit_cnt + 1'b1;
        if (r_reg.bit_cnt == 5'(SPI_CMD_BITS - 1))
        begin
          r_next.cmd = {r_reg.shift_in[6:0], r_reg.mosi_s2};
          case (r_next.cmd)
            CMD_READ_FIFO:
            begin
              r_next.shift_out = {fifo_out_valid, fifo_out_data};
              fifo_pop         = fifo_out_valid;
            end
            CMD_STATUS:
              r_next.shift_out = {r_reg.running, r_reg.overrun, ~fifo_in_ready,
                                  STATUS_CNT_W'(fifo_count)};
            CMD_NVM_READ: // [RULE_15]
            begin
              r_next.shift_out = {8'h00, nvm_data};
              r_next.nvm_ptr   = r_reg.nvm_ptr + 1'b1;
            end
            default:
              r_next.shift_out = '0;
          endcase
        end
        if (r_reg.bit_cnt == 5'(SPI_FRAME_BITS - 1) && r_reg.cmd == CMD_NVM_ADDR)
          r_next.nvm_ptr = {r_reg.shift_in[NVM_AW-2:0], r_reg.mosi_s2};
      end
      if (srise && r_reg.bit_cnt >= 5'(SPI_CMD_BITS))
      begin
        r_next.miso      = r_reg.shift_out[SPI_WORD_W-1];
        r_next.shift_out = {r_reg.shift_out[SPI_WORD_W-2:0], 1'b0};
      end
    end

    // strap capture once synchroniser has settled
    r_next.strap_s1 = addr_strap;
    r_next.strap_s2 = r_reg.strap_s1;
    if (r_reg.strap_cnt != 2'h3)
    begin
      r_next.strap_cnt = r_reg.strap_cnt + 1'b1;
      if (r_reg.strap_cnt == 2'h2)
        r_next.board_addr = r_reg.strap_s2; // [RULE_18]
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r_reg       <= '0;
      r_reg.cs_s1 <= 1'b1; // select idles high, no false frame after reset
      r_reg.cs_s2 <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  assign scan_clk_out = r_reg.clk_out;
  assign scan_clk_oe  = r_reg.clk_oe;
  assign adc_start    = r_reg.adc_start;
  assign adc_channel  = r_reg.chan;
  assign spi_miso     = r_reg.miso;
  assign spi_miso_oe  = r_reg.miso_oe;
  assign nvm_addr     = r_reg.nvm_ptr;
  assign board_addr   = r_reg.board_addr;
  assign acq_running  = r_reg.running;
  assign scan_overrun = r_reg.overrun;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [CH_W-1:0] last_push_ch;
  logic [CH_W:0]   first_pick;
  logic            int_run_reg;
  assign first_pick = next_chan(chan_mask, '0);
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      last_push_ch <= '0;
    else if (fifo_in_valid && fifo_in_ready)
      last_push_ch <= fifo_in_data[SAMPLE_W-1:RESULT_W];
  end
  // internally paced and waiting for a tick in the previous cycle
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      int_run_reg <= 1'b0;
    else
      int_run_reg <= (r_reg.state == ST_RUN) && acq_enable && clk_dir_out && (chan_mask != '0);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  AST_CLK_OE_IDLE: assert property ((r_reg.state == ST_IDLE) |-> !scan_clk_oe) // [RULE_11]
    else $error("clock terminal driven while idle");
  AST_CONV_SPACING: assert property (adc_start |=> (!adc_start) [*8]) // [RULE_05]
    else $error("conversions closer than allowed");
  AST_CONV_FULL: assert property ((adc_start && acq_enable) |->
      (r_reg.state == ST_CONV) && (r_reg.conv_cnt == CONV_CNT_W'(CONV_CYC - 1))) // [RULE_05]
    else $error("conversion not loaded with full time");
  AST_ASCENDING: assert property ((fifo_in_valid && fifo_in_ready
      && r_reg.chan != first_pick[CH_W-1:0])
      |-> r_reg.chan > last_push_ch) // [RULE_07]
    else $error("channel order not ascending");
  AST_ENABLED_ONLY: assert property (adc_start |-> chan_mask[adc_channel]) // [RULE_04]
    else $error("disabled channel converted");
  AST_RESULT_CODE: assert property ((fifo_in_valid && r_reg.state == ST_CONV) |->
      fifo_in_data == {adc_channel, adc_code}) // [RULE_01]
    else $error("stored sample differs from converter code");
  AST_TRIG_LATENCY: assert property ((r_reg.state == ST_ARMED && trig_hit && clk_dir_out
      && chan_mask != '0) |-> ##[1:LAT_MAX] (adc_start || !acq_enable)) // [RULE_09]
    else $error("trigger latency exceeded");
  AST_EXT_SCAN: assert property ((r_reg.state == ST_RUN && !clk_dir_out && acq_enable
      && r_reg.eclk_s2 && !r_reg.eclk_prev && chan_mask != '0) |=> adc_start) // [RULE_13]
    else $error("external edge did not start a scan");
  AST_INT_EDGE: assert property (($rose(scan_clk_out) && int_run_reg) |-> adc_start) // [RULE_12]
    else $error("output clock edge without scan");
  AST_MISO_CMD: assert property ((!r_reg.cs_s2 && r_reg.bit_cnt < 5'(SPI_CMD_BITS))
      |=> !spi_miso) // [RULE_16]
    else $error("data driven during command phase");
  AST_ADDR_STABLE: assert property ((r_reg.strap_cnt == 2'h3) |=> $stable(board_addr)) // [RULE_18]
    else $error("board address changed after capture");

  COV_INT_SCAN: cover property (clk_dir_out && adc_start ##[1:200] adc_start);
  COV_EXT_SCAN: cover property (!clk_dir_out && r_reg.state == ST_RUN ##1 adc_start);
  COV_TRIG_START: cover property (r_reg.state == ST_ARMED && trig_hit);
  COV_FIFO_READ: cover property (fifo_pop);
  COV_OVERRUN: cover property ($rose(scan_overrun));

endmodule : scan_acquisition_control

// ===== scan_acquisition_control_test.sv
`timescale 1ns/1ns
module scan_acquisition_control_test;
  import scan_acq_pkg::*;
  // ------------------------------------------------
  // signals and instances
  // ------------------------------------------------
  logic                ref_clk, spi_sclk, spi_mosi, host_chip_select_zero_n;
  logic                spi_miso, spi_miso_oe, scan_clk_out, scan_clk_oe, adc_start;
  logic                acq_running, scan_overrun;
  logic                nrst = 1'b0, acq_enable = 1'b0, trig_enable = 1'b0;
  logic                clk_dir_out = 1'b1, trig_in = 1'b0, scan_clk_in = 1'b0;
  logic [1:0]          trig_mode = 2'h0;
  logic [PERIOD_W-1:0] scan_period = 32'h64;
  logic [NUM_CH-1:0]   chan_mask = 8'hff;
  logic [CH_W-1:0]     adc_channel;
  logic [NVM_AW-1:0]   nvm_addr;
  logic [STRAP_W-1:0]  board_addr;
  logic [15:0]         rd;
  int                  n_errors = 0, checks = 0, c;
  wire logic [RESULT_W-1:0] adc_code = 12'ha50 + 12'(adc_channel);
  wire logic [7:0]          nvm_data = nvm_addr[7:0] ^ 8'h3c;
  wire logic                miso_line = spi_miso_oe ? spi_miso : ~spi_miso;

  scan_acquisition_control #(.FDEPTH(8)) scan_acquisition_control_inst (
    .ref_clk, .nrst, .acq_enable, .trig_enable, .trig_mode, .clk_dir_out, .scan_period,
    .chan_mask, .trig_in, .scan_clk_in, .scan_clk_out, .scan_clk_oe, .adc_start,
    .adc_channel, .adc_code, .spi_sclk, .spi_mosi, .host_chip_select_zero_n, .spi_miso,
    .spi_miso_oe, .nvm_addr, .nvm_data, .addr_strap(3'h5), .board_addr, .acq_running,
    .scan_overrun);
  spi_host_model spi_host_model_inst (.ref_clk, .sclk(spi_sclk), .mosi(spi_mosi),
    .cs_n(host_chip_select_zero_n), .miso(miso_line));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic wait_start(output int cyc);
    cyc = 0;
    do
    begin
      @(negedge ref_clk);
      cyc++;
    end
    while (adc_start !== 1'b1 && cyc < 3000);
    if (adc_start !== 1'b1)
    begin
      check("adc_start timeout", 16'h0, 16'h1);
      tally_and_finish();
    end
  endtask : wait_start

  task automatic idle(int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle
  // ------------------------------------------------
  // test sequence
  // ------------------------------------------------
  initial
  begin
    idle(10);
    nrst = 1'b1;
    idle(5);
    check("board_addr", 16'(board_addr), 16'h5);
    check("oe idle", 16'(scan_clk_oe), 16'h0);
    check("miso oe idle", 16'(spi_miso_oe), 16'h0);
    $display("test reset finished");
    acq_enable = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      wait_start(c);
      if (i > 0) check("spacing", 16'(c), 16'd80);
      if (i == 0) check("clk out", 16'(scan_clk_out), 16'h1);
      check("channel", 16'(adc_channel), 16'(i));
    end
    check("oe run", 16'(scan_clk_oe), 16'h1);
    idle(200);
    spi_host_model_inst.xfer(CMD_STATUS, 16'h0, rd);
    check("status full", rd, 16'he008);
    acq_enable = 1'b0;
    idle(5);
    check("oe stop", 16'(scan_clk_oe), 16'h0);
    check("overrun", 16'(scan_overrun), 16'h1);
    for (int i = 0; i < 8; i++)
    begin
      spi_host_model_inst.xfer(CMD_READ_FIFO, 16'h0, rd);
      check("sample", rd, {1'b1, 3'(i), 12'ha50 + 12'(i)});
    end
    c = 0;
    while (rd[15] === 1'b1 && c < 4)
    begin
      spi_host_model_inst.xfer(CMD_READ_FIFO, 16'h0, rd);
      c++;
    end
    spi_host_model_inst.xfer(CMD_STATUS, 16'h0, rd);
    check("status empty", rd, 16'h4000);
    $display("test internal scan finished");
    clk_dir_out = 1'b0;
    chan_mask = 8'h01;
    trig_enable = 1'b1;
    acq_enable = 1'b1;
    idle(10);
    trig_in = 1'b1;
    idle(50);
    check("overrun clear", 16'(scan_overrun), 16'h0);
    for (int i = 0; i < 3; i++)
    begin
      scan_clk_in = 1'b1; // 10 us period, at 100 kS/s
      wait_start(c);
      check("ext latency", 16'(c <= TRIG_LAT_CYC), 16'h1);
      check("oe input", 16'(scan_clk_oe), 16'h0);
      idle(50 - c);
      scan_clk_in = 1'b0;
      idle(50);
    end
    acq_enable = 1'b0;
    trig_in = 1'b0;
    $display("test external scan finished");
    clk_dir_out = 1'b1;
    scan_period = 32'd2000;
    for (int m = 0; m < 4; m++)
    begin
      trig_mode = 2'(m);
      trig_in = m[0];
      idle(5);
      acq_enable = 1'b1;
      idle(20);
      check("armed", 16'(acq_running), 16'h0);
      trig_in = ~m[0];
      wait_start(c);
      check("trig latency", 16'(c <= TRIG_LAT_CYC), 16'h1);
      acq_enable = 1'b0;
      idle(100);
    end
    $display("test trigger modes finished");
    spi_host_model_inst.xfer(CMD_NVM_ADDR, 16'h0123, rd);
    spi_host_model_inst.xfer(CMD_NVM_READ, 16'h0, rd);
    check("nvm byte", rd, 16'h001f);
    spi_host_model_inst.xfer(CMD_NVM_READ, 16'h0, rd);
    check("nvm next", rd, 16'h0018);
    spi_host_model_inst.xfer(8'h7f, 16'h0, rd);
    check("unknown cmd", rd, 16'h0);
    $display("test host link finished");
    tally_and_finish();
  end
endmodule : scan_acquisition_control_test

// ===== scan_sample_fifo.sv
`timescale 1ns/1ns
module scan_sample_fifo
  import scan_acq_pkg::*;
#(
  parameter int WIDTH = SAMPLE_W,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int CNT_W = $clog2(DEPTH + 1)
)(
  input  wire logic             ref_clk,   // system clock
  input  wire logic             nrst,      // async reset, active low
  input  wire logic             in_valid,  // write request
  output      logic             in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // write word
  output      logic             out_valid, // word available
  input  wire logic             out_ready, // read acknowledge
  output      logic [WIDTH-1:0] out_data,  // head word
  output      logic [CNT_W-1:0] count      // words held
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] cnt;
  } fifo_s;

  fifo_s            st_reg;
  fifo_s            st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_wr;
  logic             do_rd;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  assign in_ready  = (st_reg.cnt != CNT_W'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data  = mem[st_reg.rd_ptr];
  assign count     = st_reg.cnt;
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_ready & out_valid;

  always_comb
  begin
    st_next = st_reg;
    if (do_wr)
    begin
      st_next.wr_ptr = ptr_inc(st_reg.wr_ptr);
    end
    if (do_rd)
    begin
      st_next.rd_ptr = ptr_inc(st_reg.rd_ptr);
    end
    if (do_wr && !do_rd)
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
    else if (do_rd && !do_wr)
    begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (do_wr)
    begin
      mem[st_reg.wr_ptr] <= in_data;
    end
  end

endmodule : scan_sample_fifo

// ===== spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic ref_clk, // system clock
  output      logic sclk,    // serial clock
  output      logic mosi,    // data to device
  output      logic cs_n,    // select, active low
  input  wire logic miso     // data from device
);
  // ------------------------------------------------
  // host frame driver
  // ------------------------------------------------
  initial
  begin
    sclk = 1'b0; // idles low
    mosi = 1'b0;
    cs_n = 1'b1;
  end

  // 8 ref cycles a bit, 1.25 MHz
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] tx;
    tx = {cmd, wd};
    rd = 16'h0;
    @(negedge ref_clk) cs_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    for (int i = 23; i >= 0; i--)
    begin
      sclk = 1'b1; // launch on rise
      mosi = tx[i];
      repeat (4) @(negedge ref_clk);
      if (i < 16) rd = {rd[14:0], miso}; // take on fall
      sclk = 1'b0;
      repeat (4) @(negedge ref_clk);
    end
    cs_n = 1'b1;
    mosi = ~mosi; // released line keeps no value
    repeat (4) @(negedge ref_clk);
  endtask : xfer
endmodule : spi_host_model
